// File: hdl/sic_spi_ctrl.sv
// SPI side of a shared serial interface: mode and enable, clock output pin,
// format control, shift data register, Wishbone register slave.
// Assumes pins synchronous to MCLK and timer/time-base ticks as one-cycle pulses.
//
// Behaviour
// - Modes 000/001/010: master, clock /4,/16,/64
// - 011 time-base clock, 100 timer match/2
// - 101 SPI slave, 110 two-wire, 111 unused
// - Slave mode never drives serial clock
// - Clock output pin frequency from two-bit select
// - Disabled: all lines float, option gates enable
// - Enable rise keeps SPI control contents
// - Two-wire enable rise resets flags only
// - Mode register bit zero reads zero
// - Format bits 7..6 plain read/write, reset zero
// - Polarity bit sets clock idle level
// - Edge bit selects capture edge
// - Bit order: one MSB first, zero LSB
// - Select enable gates active-low select pin
// - Busy data write discarded, collision flag set
// - Options govern collision and select enable
// - Done flag set per word, software clears
// - Master data write starts full-duplex transfer
// - Slave shifts data on master clock edges
// - Select disabled: slave always active
// - Keeps running in processor idle mode
// - All words pass single shared data register
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module sic_spi_ctrl #(
    parameter bit OPT_SIM = 1'b1,
    parameter bit OPT_WRITE_COLLISION_FLAG = 1'b1,
    parameter bit OPT_SELECT_PIN_ENABLE = 1'b1
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic SRST,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Clock sources
    input wire logic TBC_TICK,
    input wire logic TM0_MATCH,
    // Serial pins
    input wire logic SCK_I,
    input wire logic SDI,
    input wire logic SCS_N,
    output sic_pkg::sic_spi_out_s SPI_OUT,
    output logic SCS_OE,
    // Clock output pin
    output logic PERIPH_CLK_OUT_PIN,
    // Transfer done event
    output logic DONE
);
    import sic_pkg::*;

    logic [7:0] mode_reg;
    logic [7:0] fmt_reg;
    logic [7:0] twi_reg;
    logic [7:0] shr;
    logic [4:0] div_cnt;
    logic [4:0] edge_cnt;
    logic sck_q;
    logic sdo_q;
    logic sck_in_q;
    logic pck_q;
    logic ack;
    logic [31:0] dat_q;
    logic en_q;
    sic_state_e state;

    // Decode
    wire req = WB_CYC_I && WB_STB_I;
    wire wr = req && ack && WB_WE_I && WB_SEL_I[0];
    wire wr_mode = wr && (WB_ADR_I == SIC_OFF_MODE);
    wire wr_fmt = wr && (WB_ADR_I == SIC_OFF_FMT);
    wire wr_data = wr && (WB_ADR_I == SIC_OFF_DATA);
    wire wr_twi = wr && (WB_ADR_I == SIC_OFF_TWI);
    wire [2:0] mode_f = mode_reg[SIC_MODE_LSB +: 3];
    wire [1:0] pck_sel = mode_reg[SIC_PCKSEL_LSB +: 2];
    wire en = mode_reg[SIC_EN_BIT] && OPT_SIM;
    wire is_master = (mode_f <= SIC_M_TM0);
    wire is_slave = (mode_f == SIC_M_SLAVE);
    wire is_twi = (mode_f == SIC_M_TWI);
    wire cpol = fmt_reg[SIC_CPOL_BIT];
    wire capture_edge_select = fmt_reg[SIC_CAPTURE_EDGE_SELECT_BIT];
    wire bit_order_select = fmt_reg[SIC_MLS_BIT];
    wire select_pin_enable = fmt_reg[SIC_SELECT_PIN_ENABLE_BIT] && OPT_SELECT_PIN_ENABLE;
    wire idle_lvl = ~cpol;
    wire running = (state == SIC_S_RUN);

    // Master half-period tick
    wire div_tick4 = ((div_cnt & SIC_HALF_DIV4) == SIC_HALF_DIV4);
    wire div_tick16 = ((div_cnt & SIC_HALF_DIV16) == SIC_HALF_DIV16);
    wire div_tick64 = ((div_cnt & SIC_HALF_DIV64) == SIC_HALF_DIV64);
    logic half_tick;
    always_comb begin
        case (mode_f)
            SIC_M_DIV4: half_tick = div_tick4;
            SIC_M_DIV16: half_tick = div_tick16;
            SIC_M_DIV64: half_tick = div_tick64;
            SIC_M_TBC: half_tick = TBC_TICK;
            SIC_M_TM0: half_tick = TM0_MATCH;
            default: half_tick = 1'b0;
        endcase
    end

    // Slave selected and clock edges from master
    wire slave_act = en && is_slave && (!select_pin_enable || !SCS_N);
    wire slave_edge = slave_act && (SCK_I != sck_in_q);
    wire master_edge = en && is_master && running && half_tick;
    wire sck_edge = master_edge || slave_edge;
    wire leading = !edge_cnt[0];
    // Capture on trailing edge when edge bit is 0, on leading when 1
    wire cap_edge = sck_edge && (leading == capture_edge_select);
    wire launch_edge = sck_edge && (leading != capture_edge_select);
    wire out_bit = bit_order_select ? shr[7] : shr[0];
    wire [7:0] shr_in = bit_order_select ? {shr[6:0], SDI} : {SDI, shr[7:1]};
    wire last_edge = sck_edge && (edge_cnt == SIC_EDGES_PER_WORD - 5'h01);
    wire busy = running || (edge_cnt != 5'h00);
    wire start = wr_data && !busy && en && is_master;
    wire collide = wr_data && busy;
    wire slave_abort = en && is_slave && select_pin_enable && SCS_N;
    wire en_rise = en && !en_q;

    // Read mux
    logic [7:0] rd_byte;
    always_comb begin
        case (WB_ADR_I)
            SIC_OFF_MODE: rd_byte = {mode_reg[7:1], 1'b0};
            SIC_OFF_FMT: rd_byte = fmt_reg;
            SIC_OFF_DATA: rd_byte = shr;
            SIC_OFF_TWI: rd_byte = twi_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    // Bus answer one cycle after request
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ack <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack <= req && !ack;
            if (req && !ack) begin
                dat_q <= {24'h000000, rd_byte};
            end
        end
    end
    assign WB_ACK_O = ack;
    assign WB_DAT_O = dat_q;

    // Mode and enable register; no clearing on enable rise
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            mode_reg <= SIC_MODE_RST;
            en_q <= 1'b0;
        end else begin
            en_q <= en;
            if (wr_mode) begin
                mode_reg <= {WB_DAT_I[7:1], 1'b0};
            end
        end
    end

    // Format register; hardware set wins over software clear
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            fmt_reg <= SIC_FMT_RST;
        end else begin
            if (wr_fmt) begin
                fmt_reg[7:2] <= WB_DAT_I[7:2];
                fmt_reg[SIC_WRITE_COLLISION_FLAG_BIT] <= WB_DAT_I[SIC_WRITE_COLLISION_FLAG_BIT] && OPT_WRITE_COLLISION_FLAG;
                fmt_reg[SIC_TRF_BIT] <= WB_DAT_I[SIC_TRF_BIT];
            end
            if (collide && OPT_WRITE_COLLISION_FLAG) begin
                fmt_reg[SIC_WRITE_COLLISION_FLAG_BIT] <= 1'b1;
            end
            if (last_edge) begin
                fmt_reg[SIC_TRF_BIT] <= 1'b1;
            end
        end
    end

    // Two-wire control byte: flags default on enable rise
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            twi_reg <= SIC_TWI_FLAG_RST;
        end else if (en_rise && is_twi) begin
            twi_reg <= (twi_reg & SIC_TWI_KEEP_MASK) | SIC_TWI_FLAG_RST;
        end else if (wr_twi) begin
            twi_reg <= (twi_reg & ~SIC_TWI_KEEP_MASK) | (WB_DAT_I[7:0] & SIC_TWI_KEEP_MASK);
        end
    end

    // Free divider; no idle-mode gating anywhere
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            div_cnt <= 5'h00;
        end else begin
            div_cnt <= div_cnt + 5'h01;
        end
    end

    // Master state
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state <= SIC_S_IDLE;
        end else begin
            case (state)
                SIC_S_IDLE: begin
                    if (start) begin
                        state <= SIC_S_RUN;
                    end
                end
                SIC_S_RUN: begin
                    if (last_edge || !en || !is_master) begin
                        state <= SIC_S_IDLE;
                    end
                end
                default: state <= SIC_S_IDLE;
            endcase
        end
    end

    // Edge count and clock level
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            edge_cnt <= 5'h00;
            sck_q <= 1'b1;
            sck_in_q <= 1'b1;
        end else begin
            sck_in_q <= SCK_I;
            if (last_edge || slave_abort || !en || (running && !is_master)) begin
                edge_cnt <= 5'h00;
            end else if (sck_edge) begin
                edge_cnt <= edge_cnt + 5'h01;
            end
            if (master_edge) begin
                sck_q <= ~sck_q;
            end else if (!running) begin
                sck_q <= idle_lvl;
            end
        end
    end

    // Shared data register, contents unknown after reset
    always_ff @(posedge MCLK) begin
        if (wr_data && !busy) begin
            shr <= WB_DAT_I[7:0];
        end else if (cap_edge) begin
            shr <= shr_in;
        end
    end

    // Serial output bit
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            sdo_q <= 1'b0;
        end else if (launch_edge || (edge_cnt == 5'h00 && !sck_edge)) begin
            sdo_q <= out_bit;
        end
    end

    // Clock output pin
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            pck_q <= 1'b0;
        end else begin
            case (pck_sel)
                SIC_P_DIV4: pck_q <= div_cnt[1];
                SIC_P_DIV8: pck_q <= div_cnt[2];
                SIC_P_TM0: pck_q <= pck_q ^ TM0_MATCH;
                default: pck_q <= 1'b0;
            endcase
        end
    end
    wire pck_on = mode_reg[SIC_PERIPH_CLK_OUT_ENABLE_BIT];
    assign PERIPH_CLK_OUT_PIN = pck_on && ((pck_sel == SIC_P_SYS) ? MCLK : pck_q);

    // Pin drivers
    assign SPI_OUT.sck_o = sck_q;
    assign SPI_OUT.sck_oe = en && is_master;
    assign SPI_OUT.sdo_o = sdo_q;
    assign SPI_OUT.sdo_oe = en && (is_master || slave_act);
    assign SCS_OE = 1'b0;
    assign DONE = last_edge;

    // Assertions
    logic past_valid;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            past_valid <= 1'b0;
        end else begin
            past_valid <= 1'b1;
        end
    end

    AST_DIV4: assert property (@(posedge MCLK) disable iff (SRST)
        (running && mode_f == SIC_M_DIV4 && $rose(sck_q)) |-> ##2 ($fell(sck_q) || !running))
        else $error("divide by 4 half period wrong");
    AST_MODE_RST: assert property (@(posedge MCLK)
        ($past(SRST) && !SRST) |-> (mode_f == SIC_M_NONE && fmt_reg == 8'h00))
        else $error("mode or format reset value wrong");
    AST_SLAVE_NOCLK: assert property (@(posedge MCLK) disable iff (SRST)
        is_slave |-> !SPI_OUT.sck_oe)
        else $error("slave drives serial clock");
    AST_FLOAT: assert property (@(posedge MCLK) disable iff (SRST)
        !mode_reg[SIC_EN_BIT] |-> (!SPI_OUT.sck_oe && !SPI_OUT.sdo_oe && !SCS_OE))
        else $error("lines driven while disabled");
    AST_BIT0: assert property (@(posedge MCLK) disable iff (SRST)
        (ack && WB_ADR_I == SIC_OFF_MODE) |-> (WB_DAT_O[0] == 1'b0))
        else $error("mode bit zero not zero");
    AST_IDLE: assert property (@(posedge MCLK) disable iff (SRST)
        (past_valid && !running && $past(!running)) |-> (sck_q == $past(idle_lvl)))
        else $error("clock idle level wrong");
    AST_COLL: assert property (@(posedge MCLK) disable iff (SRST)
        (collide && OPT_WRITE_COLLISION_FLAG) |=> (fmt_reg[SIC_WRITE_COLLISION_FLAG_BIT] && shr == $past(cap_edge ? shr_in : shr)))
        else $error("collision not flagged");
    AST_DONE: assert property (@(posedge MCLK) disable iff (SRST)
        DONE |=> fmt_reg[SIC_TRF_BIT] ##1 (fmt_reg[SIC_TRF_BIT] || $past(wr_fmt)))
        else $error("done flag not set");
    AST_EIGHT: assert property (@(posedge MCLK) disable iff (SRST)
        (start && mode_f == SIC_M_DIV4) |=> running[*8] ##[24:40] !running)
        else $error("word length wrong");
    AST_TWI: assert property (@(posedge MCLK) disable iff (SRST)
        (en_rise && is_twi) |=> (twi_reg[7] && twi_reg[0] && twi_reg[6:5] == 2'b00))
        else $error("two-wire flags not defaulted");
    AST_TWI_KEEP: assert property (@(posedge MCLK) disable iff (SRST)
        (en_rise && is_twi) |=> (twi_reg[4:3] == $past(twi_reg[4:3])))
        else $error("two-wire control bits not kept");
    AST_DIV16: assert property (@(posedge MCLK) disable iff (SRST)
        (running && mode_f == SIC_M_DIV16 && $rose(sck_q)) |-> ##8 ($fell(sck_q) || !running))
        else $error("divide by 16 half period wrong");
    AST_DIV64: assert property (@(posedge MCLK) disable iff (SRST)
        (running && mode_f == SIC_M_DIV64 && $rose(sck_q)) |-> ##32 ($fell(sck_q) || !running))
        else $error("divide by 64 half period wrong");
    AST_TM0_HOLD: assert property (@(posedge MCLK) disable iff (SRST)
        (running && mode_f == SIC_M_TM0 && !TM0_MATCH) |=> $stable(sck_q))
        else $error("clock moved without timer match");
    AST_TBC_HOLD: assert property (@(posedge MCLK) disable iff (SRST)
        (running && mode_f == SIC_M_TBC && !TBC_TICK) |=> $stable(sck_q))
        else $error("clock moved without time-base tick");
    AST_PCK_OFF: assert property (@(posedge MCLK) disable iff (SRST)
        !mode_reg[SIC_PERIPH_CLK_OUT_ENABLE_BIT] |-> !PERIPH_CLK_OUT_PIN)
        else $error("clock out pin active while disabled");
    AST_FREE_BITS: assert property (@(posedge MCLK) disable iff (SRST)
        wr_fmt |=> (fmt_reg[7:6] == $past(WB_DAT_I[7:6])))
        else $error("free format bits not written");
    AST_TRF_HOLD: assert property (@(posedge MCLK) disable iff (SRST)
        (fmt_reg[SIC_TRF_BIT] && !wr_fmt) |=> fmt_reg[SIC_TRF_BIT])
        else $error("done flag lost without clear");
    AST_START: assert property (@(posedge MCLK) disable iff (SRST)
        start |=> running)
        else $error("data write did not start word");
    AST_LAST: assert property (@(posedge MCLK) disable iff (SRST)
        (last_edge && master_edge) |=> !running)
        else $error("master ran past last edge");

    COV_MASTER: cover property (@(posedge MCLK) disable iff (SRST) start ##[1:300] DONE);
    COV_SLAVE: cover property (@(posedge MCLK) disable iff (SRST) (is_slave && DONE));
    COV_COLL: cover property (@(posedge MCLK) disable iff (SRST) collide);
    COV_TWI_EN: cover property (@(posedge MCLK) disable iff (SRST) (en_rise && is_twi));
    COV_TM0_WORD: cover property (@(posedge MCLK) disable iff (SRST) (mode_f == SIC_M_TM0 && DONE));
endmodule : sic_spi_ctrl

// File: common/sic_pkg.sv
// Shared constants and types of the serial interface SPI controller.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package sic_pkg;
    // Register byte offsets
    localparam logic [3:0] SIC_OFF_MODE = 4'h0;
    localparam logic [3:0] SIC_OFF_FMT = 4'h4;
    localparam logic [3:0] SIC_OFF_DATA = 4'h8;
    localparam logic [3:0] SIC_OFF_TWI = 4'hC;
    // Mode and enable register fields
    localparam int SIC_MODE_LSB = 5;
    localparam int SIC_PERIPH_CLK_OUT_ENABLE_BIT = 4;
    localparam int SIC_PCKSEL_LSB = 2;
    localparam int SIC_EN_BIT = 1;
    localparam logic [7:0] SIC_MODE_RST = 8'hE0;
    // Format register fields
    localparam int SIC_CPOL_BIT = 5;
    localparam int SIC_CAPTURE_EDGE_SELECT_BIT = 4;
    localparam int SIC_MLS_BIT = 3;
    localparam int SIC_SELECT_PIN_ENABLE_BIT = 2;
    localparam int SIC_WRITE_COLLISION_FLAG_BIT = 1;
    localparam int SIC_TRF_BIT = 0;
    localparam logic [7:0] SIC_FMT_RST = 8'h00;
    // Two-wire control byte: keep bits and flag defaults
    localparam logic [7:0] SIC_TWI_KEEP_MASK = 8'h18;
    localparam logic [7:0] SIC_TWI_FLAG_RST = 8'h81;
    // Half-period masks of the divided serial clock
    localparam logic [4:0] SIC_HALF_DIV4 = 5'h01;
    localparam logic [4:0] SIC_HALF_DIV16 = 5'h07;
    localparam logic [4:0] SIC_HALF_DIV64 = 5'h1F;
    // Edges in one word: two per bit
    localparam logic [4:0] SIC_EDGES_PER_WORD = 5'h10;

    typedef enum logic [2:0] {
        SIC_M_DIV4 = 3'b000,
        SIC_M_DIV16 = 3'b001,
        SIC_M_DIV64 = 3'b010,
        SIC_M_TBC = 3'b011,
        SIC_M_TM0 = 3'b100,
        SIC_M_SLAVE = 3'b101,
        SIC_M_TWI = 3'b110,
        SIC_M_NONE = 3'b111
    } sic_mode_e;

    typedef enum logic [1:0] {
        SIC_P_SYS = 2'b00,
        SIC_P_DIV4 = 2'b01,
        SIC_P_DIV8 = 2'b10,
        SIC_P_TM0 = 2'b11
    } sic_pck_e;

    typedef enum logic [0:0] {
        SIC_S_IDLE = 1'b0,
        SIC_S_RUN = 1'b1
    } sic_state_e;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
    } sic_spi_out_s;
endpackage : sic_pkg

// File: verification/sic_spi_peer.sv
// Behavioural SPI slave facing the controller's master pins.
// Assumes its clock input stands still between words.
`timescale 1ns/1ps
module sic_spi_peer (
    // Serial lines
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // Setup from the bench
    input wire logic arm,
    input wire logic cpol,
    input wire logic capture_edge_select,
    input wire logic msb,
    input wire logic [7:0] tx,
    output logic [7:0] rx,
    output int edges
);
    logic [7:0] sh;

    assign miso = msb ? sh[7] : sh[0];

    // Shift only after capture, so the bit holds across the launch edge
    always @(posedge arm or sck) begin
        if (arm) begin
            sh = tx;
            edges = 0;
        end else begin
            edges = edges + 1;
            if ((sck == cpol) == capture_edge_select) begin
                rx = msb ? {rx[6:0], mosi} : {mosi, rx[7:1]};
                sh = msb ? {sh[6:0], 1'b0} : {1'b0, sh[7:1]};
            end
        end
    end
endmodule : sic_spi_peer

// File: verification/tb_top.sv
// Self-checking bench of the SPI controller: registers, master and slave words.
// Assumes the peer model on the master pins and free-running tick inputs.
`timescale 1ns/1ps
module tb_top;
    import sic_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, tbc = 1'b0, tm0 = 1'b0;
    logic sck_i = 1'b0, sdi_tb = 1'b0, scs_n = 1'b1, scs_oe, periph_clk_out_pin, done, miso, slave = 1'b0;
    logic arm = 1'b0, cpol = 1'b0, capture_edge_select = 1'b0, msb = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [7:0] ptx = 8'h00, prx;
    sic_spi_out_s spi_out;
    int edges, err_total = 0, samples_checked = 0, done_cnt = 0, pck_cnt = 0, tcnt = 0;

    sic_spi_ctrl i_dut (.MCLK(mclk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .TBC_TICK(tbc), .TM0_MATCH(tm0), .SCK_I(sck_i), .SDI(slave ? sdi_tb : miso),
        .SCS_N(scs_n), .SPI_OUT(spi_out), .SCS_OE(scs_oe), .PERIPH_CLK_OUT_PIN(periph_clk_out_pin), .DONE(done));
    sic_spi_peer i_peer (.sck(spi_out.sck_o), .mosi(spi_out.sdo_o), .miso(miso), .arm(arm),
        .cpol(cpol), .capture_edge_select(capture_edge_select), .msb(msb), .tx(ptx), .rx(prx), .edges(edges));

    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // Ticks: time base every 5 cycles, timer match every 7
    always @(posedge mclk) begin
        tcnt <= tcnt + 1;
        tbc <= (tcnt % 5 == 4);
        tm0 <= (tcnt % 7 == 6);
        if (done === 1'b1) begin
            done_cnt <= done_cnt + 1;
        end
    end

    always @(posedge periph_clk_out_pin) begin
        pck_cnt++;
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chkr(input string what, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chkr

    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do @(posedge mclk); while (ack !== 1'b1);
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] r;
        wb(1'b0, a, 8'h00, r);
        chk8(what, exp, r);
    endtask : rd_chk

    task automatic t_regs;
        rd_chk("mode reset", SIC_OFF_MODE, 8'hE0);
        rd_chk("format reset", SIC_OFF_FMT, 8'h00);
        chk8("pin enables off", 8'h00, {5'h00, spi_out.sck_oe, spi_out.sdo_oe, scs_oe});
        rd_chk("unmapped", 4'h2, 8'h00);
        wr(SIC_OFF_MODE, 8'hFF);
        rd_chk("mode low bit", SIC_OFF_MODE, 8'hFE);
        wr(SIC_OFF_MODE, 8'hE0);
        wr(SIC_OFF_FMT, 8'hE8);
        wr(SIC_OFF_MODE, 8'hE2);
        rd_chk("format kept on enable", SIC_OFF_FMT, 8'hE8);
        wr(SIC_OFF_FMT, 8'hC0);
        rd_chk("free bits", SIC_OFF_FMT, 8'hC0);
        wr(SIC_OFF_TWI, 8'hFF);
        wr(SIC_OFF_MODE, 8'hC0);
        wr(SIC_OFF_MODE, 8'hC2);
        rd_chk("two-wire byte", SIC_OFF_TWI, 8'h99);
        $display("registers test done");
    endtask : t_regs

    task automatic t_master(input logic [2:0] m, input int half, input logic [7:0] f, input logic [7:0] d);
        int n = 0;
        int c0;
        int t0;
        wr(SIC_OFF_FMT, f);
        wr(SIC_OFF_MODE, {m, 5'h02});
        repeat (2) @(posedge mclk);
        chk8("clock idle", {6'h00, 1'b1, ~f[5]}, {6'h00, spi_out.sck_oe, spi_out.sck_o});
        {cpol, capture_edge_select, msb} = f[5:3];
        ptx = ~d;
        arm = 1'b1;
        #1 arm = 1'b0;
        c0 = done_cnt;
        wr(SIC_OFF_DATA, d);
        t0 = tcnt;
        if (half == 8) begin
            repeat (10) @(posedge mclk);
            wr(SIC_OFF_DATA, 8'h00);
            rd_chk("collision", SIC_OFF_FMT, f | 8'h02);
        end
        while (done_cnt == c0 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        chkr("word cycles", 15 * half, 16 * half + 30, tcnt - t0);
        repeat (3) @(posedge mclk);
        chkr("clock edges", 16, 16, edges);
        chk8("peer received", d, prx);
        rd_chk("data received", SIC_OFF_DATA, ~d);
        rd_chk("done flag", SIC_OFF_FMT, f | (half == 8 ? 8'h03 : 8'h01));
        wr(SIC_OFF_FMT, f);
        rd_chk("flags cleared", SIC_OFF_FMT, f);
        $display("master test mode %0d done", m);
    endtask : t_master

    task automatic t_pck;
        int dv[4] = '{1, 4, 8, 14};
        for (int s = 0; s < 4; s++) begin
            wr(SIC_OFF_MODE, {3'b111, 1'b1, s[1:0], 2'b00});
            pck_cnt = 0;
            repeat (64) @(posedge mclk);
            chkr("clock out rises", 64 / dv[s] - 1, 64 / dv[s] + 1, pck_cnt);
        end
        $display("clock out test done");
    endtask : t_pck

    task automatic t_slave(input logic cs, input logic [7:0] d, input logic [7:0] rxd);
        logic [7:0] got;
        int c0;
        slave = 1'b1;
        wr(SIC_OFF_FMT, {5'h07, cs, 2'b00});
        wr(SIC_OFF_MODE, 8'hA2);
        wr(SIC_OFF_DATA, d);
        c0 = done_cnt;
        @(posedge mclk);
        scs_n <= ~cs;
        for (int i = 7; i >= 0; i--) begin
            sdi_tb <= rxd[i];
            repeat (4) @(posedge mclk);
            got[i] = spi_out.sdo_o;
            sck_i <= 1'b1;
            repeat (4) @(posedge mclk);
            sck_i <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        scs_n <= 1'b1;
        sdi_tb <= ~sdi_tb;
        chkr("slave words", c0 + 1, c0 + 1, done_cnt);
        chk8("slave sent", d, got);
        chk8("slave clock drive", 8'h00, {7'h00, spi_out.sck_oe});
        rd_chk("slave received", SIC_OFF_DATA, rxd);
        $display("slave test select %0d done", cs);
    endtask : t_slave

    task automatic give_verdict;
        $display("Counts: %0d checked, %0d mismatched", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        $display("Error watchdog expected finish seen hang");
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_regs();
        t_master(3'b000, 2, 8'h08, 8'hA5);
        t_master(3'b001, 8, 8'h30, 8'h3C);
        t_master(3'b010, 32, 8'h18, 8'h96);
        t_master(3'b011, 5, 8'h28, 8'h5A);
        t_master(3'b100, 7, 8'h00, 8'hC3);
        t_pck();
        t_slave(1'b1, 8'h5A, 8'hC3);
        t_slave(1'b0, 8'h81, 8'h7E);
        give_verdict();
    end
endmodule : tb_top
